/* core/lcc_charge_ctrl.sv */
// Charge state controller of a single-cell lithium linear charger.
`timescale 1ns/100ps
module lcc_charge_ctrl #(
  parameter int unsigned SOFTSTART_CYCLES = lcc_pkg::SOFTSTART_CYC,
  parameter int unsigned REVAL_CYCLES = lcc_pkg::REVAL_CYC,
  parameter int unsigned PRE_FAULT_CYCLES = lcc_pkg::PRE_FAULT_CYC,
  parameter int unsigned VALID_CYCLES = lcc_pkg::VALID_CYC,
  parameter int unsigned EOC_HOLD_CYCLES = lcc_pkg::EOC_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vin_above_rise,
  input wire logic vin_above_sleep,
  input wire logic vin_above_fall,
  input wire logic vin_above_hold,
  input wire logic vin_overvoltage,
  input wire logic vin_below_ov_release,
  input wire logic bat_above_min,
  input wire logic bat_at_float,
  input wire logic bat_below_recharge,
  input wire logic bat_shorted,
  input wire logic ibat_below_end,
  input wire logic therm_cold,
  input wire logic therm_warm,
  input wire logic therm_hot,
  input wire logic therm_grounded,
  input wire logic therm_open,
  input wire logic set_shorted,
  input wire logic die_thermal_reg,
  input wire logic die_shutdown,
  output logic input_switch_en,
  output logic battery_pass_switch_en,
  output logic body_select_switch_en,
  output logic validation_load_en,
  output logic [1:0] current_select,
  output logic float_reduce,
  output logic therm_source_en,
  output logic charge_ind_out,
  output logic charge_ind_oe_n,
  output logic [8:0] state_out
);
  import lcc_pkg::*;

  localparam int NSYNC = 19;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] val;
    lcc_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] aux;
    logic ov_seen;
    logic rise_prev;
    logic sw_in;
    logic sw_bat;
    logic sw_body;
    logic load;
    logic [1:0] cur;
    logic flt_red;
    logic src_en;
    logic ind_oe_n;
    logic ind_drv;
  } lcc_regs_t;

  lcc_regs_t st_r;
  lcc_regs_t st_nxt;
  logic [NSYNC-1:0] raw;

  assign raw = {vin_above_rise, vin_above_sleep, vin_above_fall,
                vin_above_hold, vin_overvoltage, vin_below_ov_release,
                bat_above_min, bat_at_float, bat_below_recharge, bat_shorted,
                ibat_below_end, therm_cold, therm_warm, therm_hot,
                therm_grounded, therm_open, set_shorted, die_thermal_reg,
                die_shutdown};

  localparam int I_RISE = 18;
  localparam int I_SLP = 17;
  localparam int I_FALL = 16;
  localparam int I_HOLD = 15;
  localparam int I_OV = 14;
  localparam int I_OVREL = 13;
  localparam int I_BMIN = 12;
  localparam int I_FLT = 11;
  localparam int I_RCH = 10;
  localparam int I_SHORT = 9;
  localparam int I_IEND = 8;
  localparam int I_COLD = 7;
  localparam int I_WARM = 6;
  localparam int I_HOT = 5;
  localparam int I_GND = 4;
  localparam int I_OPEN = 3;
  localparam int I_SET = 2;
  localparam int I_TREG = 1;
  localparam int I_TSD = 0;

  function automatic logic [TMR_W-1:0] cyc(input int unsigned n);
    cyc = TMR_W'(n);
  endfunction

  logic temp_block;
  logic warm;
  logic charging;
  logic [TMR_W-1:0] tmr_inc;

  always_comb begin
    st_nxt = st_r;
    tmr_inc = st_r.tmr + cyc(1);
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < NSYNC; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.val[i] = st_r.s3[i];
      end
    end
    // A grounded pin masks every thermistor threshold, but not die shutdown.
    temp_block = !st_r.val[I_GND] &&
                 (st_r.val[I_COLD] || st_r.val[I_HOT]);
    temp_block = temp_block || (st_r.val[I_OPEN] && !st_r.val[I_GND]);
    temp_block = temp_block || st_r.val[I_TSD];
    warm = !st_r.val[I_GND] && st_r.val[I_WARM] && !temp_block;
    charging = (st_r.st == ST_PRE) || (st_r.st == ST_FAST) ||
               (st_r.st == ST_FLOAT);
    st_nxt.src_en = !st_r.val[I_GND];
    st_nxt.rise_prev = st_r.val[I_RISE];
    st_nxt.tmr = tmr_inc;
    if (st_r.val[I_OV]) begin
      st_nxt.ov_seen = 1'b1;
    end else if (st_r.val[I_OVREL]) begin
      st_nxt.ov_seen = 1'b0;
    end
    case (st_r.st)
      ST_SLEEP: begin
        st_nxt.tmr = '0;
        if (st_r.val[I_RISE]) begin
          st_nxt.st = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (st_r.val[I_SET]) begin
          st_nxt.st = ST_FAULT;
        end else if (!st_r.val[I_FALL]) begin
          st_nxt.st = ST_SLEEP;
        end else if (st_r.tmr >= cyc(SOFTSTART_CYCLES - 1) &&
                     !st_r.ov_seen) begin
          st_nxt.st = ST_VALID;
          st_nxt.tmr = '0;
        end
      end
      ST_VALID: begin
        if (st_r.val[I_SET]) begin
          st_nxt.st = ST_FAULT;
        end else if (!st_r.val[I_HOLD] || st_r.ov_seen) begin
          st_nxt.st = ST_RETRY;
          st_nxt.tmr = '0;
        end else if (st_r.tmr >= cyc(VALID_CYCLES - 1)) begin
          st_nxt.st = ST_PRE;
          st_nxt.tmr = '0;
          st_nxt.aux = '0;
        end
      end
      ST_RETRY: begin
        if (!st_r.val[I_FALL]) begin
          st_nxt.st = ST_SLEEP;
        end else if (!st_r.val[I_SLP]) begin
          st_nxt.tmr = tmr_inc; // Load discharges input meanwhile.
        end
        if (st_r.val[I_FALL] && st_r.val[I_SLP] && !st_r.ov_seen &&
            st_r.tmr >= cyc(REVAL_CYCLES - 1)) begin
          st_nxt.st = ST_VALID;
          st_nxt.tmr = '0;
        end
      end
      ST_PRE: begin
        if (!st_r.val[I_SHORT] && st_r.val[I_BMIN]) begin
          st_nxt.st = ST_FAST;
        end else if (st_r.val[I_SHORT] &&
                     st_r.aux >= cyc(PRE_FAULT_CYCLES - 1)) begin
          st_nxt.st = ST_FAULT;
        end
        if (!temp_block) begin
          st_nxt.aux = st_r.aux + cyc(1);
        end
      end
      ST_FAST: begin
        if (st_r.val[I_SHORT]) begin
          st_nxt.st = ST_FAULT;
        end else if (st_r.val[I_FLT]) begin
          st_nxt.st = ST_FLOAT;
          st_nxt.tmr = '0;
        end
      end
      ST_FLOAT: begin
        if (st_r.val[I_SHORT]) begin
          st_nxt.st = ST_FAULT;
        end else if (!st_r.val[I_FLT] || temp_block) begin
          st_nxt.tmr = '0;
        end else if (st_r.val[I_IEND] &&
                     st_r.tmr >= cyc(EOC_HOLD_CYCLES - 1)) begin
          st_nxt.st = ST_DONE;
        end
      end
      ST_DONE: begin
        if (st_r.val[I_RCH]) begin
          st_nxt.st = ST_FAST;
        end
      end
      ST_FAULT: begin
        st_nxt.tmr = '0;
      end
      default: begin
        st_nxt.st = ST_SLEEP;
      end
    endcase
    // Falling input leaves any charging or done state.
    if ((charging || st_r.st == ST_DONE) &&
        (!st_r.val[I_FALL] || !st_r.val[I_SLP] || st_r.val[I_OV])) begin
      st_nxt.st = ST_RETRY;
      st_nxt.tmr = '0;
    end
    // A new input rise clears the latched fault.
    if (st_r.st == ST_FAULT && !st_r.val[I_FALL]) begin
      st_nxt.st = ST_SLEEP;
    end
    if (st_r.val[I_RISE] && !st_r.rise_prev && st_r.st == ST_FAULT) begin
      st_nxt.st = ST_SOFT;
      st_nxt.tmr = '0;
    end
    st_nxt.sw_in = (st_nxt.st != ST_SLEEP) &&
                   (st_nxt.st != ST_FAULT);
    st_nxt.sw_body = st_nxt.sw_in;
    st_nxt.sw_bat = (st_nxt.st == ST_PRE || st_nxt.st == ST_FAST ||
                     st_nxt.st == ST_FLOAT || st_nxt.st == ST_DONE) &&
                    !st_r.val[I_OV];
    st_nxt.load = (st_nxt.st == ST_VALID) ||
                  (st_nxt.st == ST_RETRY && !st_r.val[I_SLP]);
    if (!(st_nxt.st == ST_PRE || st_nxt.st == ST_FAST ||
          st_nxt.st == ST_FLOAT) || temp_block) begin
      st_nxt.cur = CUR_OFF;
    end else if (st_nxt.st == ST_PRE) begin
      st_nxt.cur = CUR_PRE;
    end else if (warm) begin
      st_nxt.cur = CUR_WARM;
    end else begin
      st_nxt.cur = CUR_FAST;
    end
    st_nxt.flt_red = warm;
    // Low drive while current flows, including thermal regulation.
    st_nxt.ind_oe_n = !(st_nxt.cur != CUR_OFF);
    // Open-drain pin: only the enable moves, the driven level stays low.
    st_nxt.ind_drv = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.st <= ST_SLEEP;
      st_r.ind_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign input_switch_en = st_r.sw_in;
  assign battery_pass_switch_en = st_r.sw_bat;
  assign body_select_switch_en = st_r.sw_body;
  assign validation_load_en = st_r.load;
  assign current_select = st_r.cur;
  assign float_reduce = st_r.flt_red;
  assign therm_source_en = st_r.src_en;
  assign charge_ind_out = st_r.ind_drv;
  assign charge_ind_oe_n = st_r.ind_oe_n;
  assign state_out = st_r.st;

  property p_fault_off;
    @(posedge clk) disable iff (!rst_n)
    st_r.st == ST_FAULT |->
      !battery_pass_switch_en && !input_switch_en && !body_select_switch_en;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("Switches on in fault state.");

  property p_sleep_off;
    @(posedge clk) disable iff (!rst_n)
    st_r.st == ST_SLEEP && $past(st_r.st) == ST_SLEEP |->
      !input_switch_en && !battery_pass_switch_en && !body_select_switch_en;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("Switch on during sleep.");

  property p_ind_low;
    @(posedge clk) disable iff (!rst_n)
    current_select != CUR_OFF |-> !charge_ind_oe_n;
  endproperty
  a_ind_low: assert property (p_ind_low)
    else $error("Indicator released while charging.");

  property p_no_pass_prevalid;
    @(posedge clk) disable iff (!rst_n)
    st_r.st == ST_SOFT || st_r.st == ST_VALID |-> !battery_pass_switch_en;
  endproperty
  a_no_pass_prevalid: assert property (p_no_pass_prevalid)
    else $error("Pass switch on before validation.");

  property p_done_released;
    @(posedge clk) disable iff (!rst_n)
    st_r.st == ST_DONE |-> charge_ind_oe_n;
  endproperty
  a_done_released: assert property (p_done_released)
    else $error("Indicator low after completion.");

  property p_load_valid;
    @(posedge clk) disable iff (!rst_n)
    st_r.st == ST_VALID |-> validation_load_en;
  endproperty
  a_load_valid: assert property (p_load_valid)
    else $error("Validation load missing.");

  property p_hot_stop;
    @(posedge clk) disable iff (!rst_n)
    st_r.val[I_HOT] && !st_r.val[I_GND] |=> current_select == CUR_OFF;
  endproperty
  a_hot_stop: assert property (p_hot_stop)
    else $error("Charging while hot.");

  property p_warm_red;
    @(posedge clk) disable iff (!rst_n)
    st_r.st == ST_FAST && warm && $stable(st_r.st) |=>
      float_reduce;
  endproperty
  a_warm_red: assert property (p_warm_red)
    else $error("Warm reduction missing.");
endmodule

/* core/lcc_pkg.sv */
// Timing, reduction, current-select and state constants of the charge controller.
package lcc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SOFTSTART_MS = 16;
  localparam int unsigned REVAL_MS = 2000;
  localparam int unsigned PRE_FAULT_MS = 32;
  localparam int unsigned VALID_US = 1000;
  localparam int unsigned EOC_HOLD_MS = 32;
  localparam int unsigned SOFTSTART_CYC = CLK_HZ / 1000 * SOFTSTART_MS;
  localparam int unsigned REVAL_CYC = CLK_HZ / 1000 * REVAL_MS;
  localparam int unsigned PRE_FAULT_CYC = CLK_HZ / 1000 * PRE_FAULT_MS;
  localparam int unsigned VALID_CYC = CLK_HZ / 1000000 * VALID_US;
  localparam int unsigned EOC_HOLD_CYC = CLK_HZ / 1000 * EOC_HOLD_MS;
  // Pre-charge divisor is 5.2, kept as tenths.
  localparam int unsigned PRE_DIV_TENTHS = 52;
  localparam int unsigned END_DIV = 10;
  localparam int unsigned WARM_CUR_PCT = 20;
  localparam int unsigned WARM_FLOAT_MV = 200;
  localparam int unsigned TMR_W = 27;
  localparam logic [1:0] CUR_OFF = 2'h0;
  localparam logic [1:0] CUR_PRE = 2'h1;
  localparam logic [1:0] CUR_FAST = 2'h2;
  localparam logic [1:0] CUR_WARM = 2'h3;

  typedef enum logic [8:0] {
    ST_SLEEP    = 9'h001,
    ST_SOFT     = 9'h002,
    ST_VALID    = 9'h004,
    ST_RETRY    = 9'h008,
    ST_PRE      = 9'h010,
    ST_FAST     = 9'h020,
    ST_FLOAT    = 9'h040,
    ST_DONE     = 9'h080,
    ST_FAULT    = 9'h100
  } lcc_state_t;
endpackage

/* verification/lcc_supply_model.sv */
// Behavioural model of the input supply, battery pack and thermistor.
`timescale 1ns/100ps
module lcc_supply_model (
  input wire logic clk,
  input wire logic src_on,
  input wire logic src_weak,
  input wire logic src_ov,
  input wire logic bat_hold,
  input wire logic bat_drain,
  input wire logic bat_short,
  input wire logic [2:0] therm_mode,
  input wire logic pass_en,
  input wire logic load_en,
  output logic [15:0] cmp
);
  logic [7:0] lvl = 8'h00;
  // The cell charges one step a cycle while the pass switch conducts and bat_hold is low, up to 8'h82.
  always @(posedge clk) begin
    if (bat_short) begin
      lvl <= 8'h00;
    end else if (bat_drain) begin
      lvl <= 8'h55;
    end else if (pass_en && !bat_hold && lvl < 8'h82) begin
      lvl <= lvl + 8'h01;
    end
  end
  // A grounded pin also reads as hot and an open pin as cold.
  assign cmp = {therm_mode == 3'h5, therm_mode == 3'h4,
    therm_mode == 3'h3 || therm_mode == 3'h4,
    therm_mode == 3'h2 || therm_mode == 3'h3 || therm_mode == 3'h4,
    therm_mode == 3'h1 || therm_mode == 3'h5,
    lvl >= 8'h78, lvl < 8'h0A, lvl < 8'h5A, lvl >= 8'h64, lvl >= 8'h28,
    !src_ov, src_ov, src_on && !(src_weak && load_en), src_on, src_on,
    src_on};
endmodule

/* verification/test_lcc_charge_ctrl.sv */
// Self-checking testbench of the charge state controller.
`timescale 1ns/100ps
module test_lcc_charge_ctrl;
  import lcc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic src_on = 1'b0, src_weak = 1'b0, src_ov = 1'b0, bat_hold = 1'b0;
  logic bat_drain = 1'b0, bat_short = 1'b0, set_shorted = 1'b0;
  logic die_reg = 1'b0, die_sd = 1'b0;
  logic [2:0] therm_mode = 3'h0;
  logic [15:0] cmp;
  logic ins, pas, body, load, flr, tsrc, ind, oe_n;
  logic [1:0] cur;
  logic [8:0] st;
  logic [6:0] sw;
  logic [3:0] texp [1:5] = '{4'h1, 4'hE, 4'h1, 4'h8, 4'h1};
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  assign sw = {ins, pas, load, cur, flr, oe_n};
  always #12.5 clk = ~clk;
  lcc_supply_model u_lcc_supply_model (.clk(clk), .src_on(src_on),
    .src_weak(src_weak), .src_ov(src_ov), .bat_hold(bat_hold),
    .bat_drain(bat_drain), .bat_short(bat_short), .therm_mode(therm_mode),
    .pass_en(pas), .load_en(load), .cmp(cmp));
  lcc_charge_ctrl #(.SOFTSTART_CYCLES(20), .REVAL_CYCLES(50),
    .PRE_FAULT_CYCLES(20), .VALID_CYCLES(10), .EOC_HOLD_CYCLES(10))
    u_lcc_charge_ctrl (.clk(clk), .rst_n(rst_n), .vin_above_rise(cmp[0]),
    .vin_above_sleep(cmp[1]), .vin_above_fall(cmp[2]),
    .vin_above_hold(cmp[3]), .vin_overvoltage(cmp[4]),
    .vin_below_ov_release(cmp[5]), .bat_above_min(cmp[6]),
    .bat_at_float(cmp[7]), .bat_below_recharge(cmp[8]),
    .bat_shorted(cmp[9]), .ibat_below_end(cmp[10]), .therm_cold(cmp[11]),
    .therm_warm(cmp[12]), .therm_hot(cmp[13]), .therm_grounded(cmp[14]),
    .therm_open(cmp[15]), .set_shorted(set_shorted),
    .die_thermal_reg(die_reg), .die_shutdown(die_sd),
    .input_switch_en(ins), .battery_pass_switch_en(pas),
    .body_select_switch_en(body), .validation_load_en(load),
    .current_select(cur), .float_reduce(flr), .therm_source_en(tsrc),
    .charge_ind_out(ind), .charge_ind_oe_n(oe_n), .state_out(st));
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [8:0] exp,
                     input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_st(input logic [8:0] s);
    int n;
    n = 0;
    while (st !== s && n < 400) begin
      step(1);
      n++;
    end
    chk("state", s, st);
  endtask
  task automatic t_start;
    src_on = 1'b1;
    wait_st(ST_SOFT);
    chk("soft", 9'h041, {2'h0, sw});
    chk("drive level", 9'h000, {8'h00, ind});
    chk("source on", 9'h001, {8'h00, tsrc});
    wait_st(ST_VALID);
    chk("valid", 9'h051, {2'h0, sw});
    wait_st(ST_PRE);
    chk("pre", 9'h064, {2'h0, sw});
    bat_hold = 1'b1;
    step(2);
    bat_hold = 1'b0;
    wait_st(ST_FAST);
    bat_hold = 1'b1;
    chk("fast", 9'h068, {2'h0, sw});
  endtask
  task automatic t_therm;
    for (int m = 1; m <= 5; m++) begin
      therm_mode = m[2:0];
      step(8);
      chk("therm", {5'h00, texp[m]}, {5'h00, cur, flr, oe_n});
      if (m == 4) begin
        chk("source", 9'h000, {8'h00, tsrc});
      end
      therm_mode = 3'h0;
      step(8);
      wait_st(ST_FAST);
    end
    die_reg = 1'b1;
    step(8);
    chk("regulation", 9'h000, {8'h00, oe_n});
    die_reg = 1'b0;
    die_sd = 1'b1;
    step(8);
    chk("shutdown", 9'h001, {8'h00, oe_n});
    die_sd = 1'b0;
    wait_st(ST_FAST);
  endtask
  task automatic t_ov;
    src_ov = 1'b1;
    step(8);
    chk("overvoltage", 9'h001, {7'h00, pas, oe_n});
    src_ov = 1'b0;
    wait_st(ST_VALID);
    chk("revalidate", 9'h000, {8'h00, pas});
    wait_st(ST_FAST);
  endtask
  task automatic t_done;
    bat_hold = 1'b0;
    wait_st(ST_FLOAT);
    wait_st(ST_DONE);
    chk("done", 9'h001, {8'h00, oe_n});
    bat_drain = 1'b1;
    step(8);
    chk("recharge", 9'h000, {8'h00, oe_n});
    bat_drain = 1'b0;
    wait_st(ST_DONE);
  endtask
  task automatic off_on(input logic sc);
    int n;
    src_on = 1'b0;
    wait_st(ST_SLEEP);
    chk("sleep", 9'h001, {1'b0, body, sw});
    set_shorted = sc;
    bat_short = !sc;
    src_on = 1'b1;
    if (sc) begin
      wait_st(ST_FAULT);
    end else begin
      wait_st(ST_PRE);
      n = 0;
      while (st === ST_PRE && n < 100) begin
        step(1);
        n++;
      end
      chk("prefault", 9'h001, {8'h00, n >= 18 && n <= 26});
    end
    chk("fault", ST_FAULT, st);
    bat_short = 1'b0;
    set_shorted = 1'b0;
    step(30);
    chk("latched", 9'h001, {1'b0, body, sw});
  endtask
  task automatic t_retry;
    int n;
    src_on = 1'b0;
    wait_st(ST_SLEEP);
    src_weak = 1'b1;
    src_on = 1'b1;
    wait_st(ST_RETRY);
    chk("retry", 9'h001, {6'h00, pas, load, oe_n});
    n = 0;
    while (st === ST_RETRY && n < 200) begin
      step(1);
      n++;
    end
    chk("period", 9'h001, {8'h00, n >= 48 && n <= 56});
    src_weak = 1'b0;
    wait_st(ST_FAST);
    bat_short = 1'b1;
    step(8);
    chk("short", ST_FAULT, st);
    chk("short off", 9'h001, {1'b0, body, sw});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(4);
    t_start();
    t_therm();
    t_ov();
    t_done();
    off_on(1'b0);
    off_on(1'b1);
    t_retry();
    give_verdict();
  end
endmodule
